// *** rtl/dps_param_bank.sv ***
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
// What this block does
// - position word inverts cmd, additive, feedback 1/2
// - bit one inverts value, zero passes
// - torque word inverts cmd, additive, feedback
// - position method: none, linear, rotary
// - bit 3 selects preferred or parameter scaling
// - position bit4, bit5, 8-15 reserved
// - bit 6 selects motor shaft or load
// - position bit 7 absolute or modulo
// - torque method percentage; bits 4,5,7-15 reserved
// - acceleration method codes incl. ramp time
// - acceleration bit 5 selects time unit
// - acceleration multiplier fixed read-only one
module dps_param_bank (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [7:0]             paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire dps_pkg::dps_link_t     link_state_i,
  input  wire dps_pkg::dps_pos_vals_t pos_in_i,
  input  wire dps_pkg::dps_trq_vals_t trq_in_i,
  output dps_pkg::dps_pos_vals_t      pos_out_o,
  output dps_pkg::dps_trq_vals_t      trq_out_o,
  output dps_pkg::dps_scale_t         pos_cfg_o,
  output dps_pkg::dps_scale_t         trq_cfg_o,
  output dps_pkg::dps_scale_t         acc_cfg_o
);
  import dps_pkg::*;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        mapped;
  logic        wr_ok;
  logic        wr_rej;
  logic [15:0] wdat;

  assign setup     = psel_i && !penable_i;
  assign access    = psel_i && penable_i;
  assign wdat      = pwdata_i[15:0];
  assign mapped    = (paddr_i == OFF_POS_INV) || (paddr_i == OFF_POS_SCL) || (paddr_i == OFF_TRQ_INV) ||
                     (paddr_i == OFF_TRQ_SCL) || (paddr_i == OFF_ACC_SCL) || (paddr_i == OFF_ACC_MULT) ||
                     (paddr_i == OFF_STATUS);
  // status and the fixed multiplier are not gated by link state
  assign wr_ok     = access && pwrite_i && (link_state_i == DPS_LINK_PREOP);
  assign wr_rej    = access && pwrite_i && (link_state_i != DPS_LINK_PREOP) && mapped &&
                     (paddr_i != OFF_STATUS) && (paddr_i != OFF_ACC_MULT);
  // no wait state; read data comes from a flop loaded in setup
  assign pready_o  = access;
  assign pslverr_o = access && !mapped;

  // ------------------------------------------------------------
  // parameter words
  // ------------------------------------------------------------
  logic [15:0] pos_inv_r, pos_inv_nxt;
  logic [15:0] pos_scl_r, pos_scl_nxt;
  logic [15:0] trq_inv_r, trq_inv_nxt;
  logic [15:0] trq_scl_r, trq_scl_nxt;
  logic [15:0] acc_scl_r, acc_scl_nxt;
  logic        rej_r,     rej_nxt;
  logic [31:0] rdata_r,   rdata_nxt;

  always_comb begin
    pos_inv_nxt = pos_inv_r;
    pos_scl_nxt = pos_scl_r;
    trq_inv_nxt = trq_inv_r;
    trq_scl_nxt = trq_scl_r;
    acc_scl_nxt = acc_scl_r;
    rej_nxt     = rej_r;
    if (wr_ok) begin
      case (paddr_i)
        OFF_POS_INV: pos_inv_nxt = wdat & MASK_POS_INV;
        OFF_POS_SCL: pos_scl_nxt = wdat & MASK_POS_SCL;
        OFF_TRQ_INV: trq_inv_nxt = wdat & MASK_TRQ_INV;
        OFF_TRQ_SCL: trq_scl_nxt = wdat & MASK_TRQ_SCL;
        OFF_ACC_SCL: acc_scl_nxt = wdat & MASK_ACC_SCL;
        default: ;
      endcase
    end
    // write-one clears the sticky flag, a new rejection wins
    if (access && pwrite_i && (paddr_i == OFF_STATUS) && pwdata_i[BIT_REJECTED]) begin
      rej_nxt = 1'b0;
    end
    if (wr_rej) begin
      rej_nxt = 1'b1;
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (setup) begin
      case (paddr_i)
        OFF_POS_INV:  rdata_nxt = {16'h0000, pos_inv_r};
        OFF_POS_SCL:  rdata_nxt = {16'h0000, pos_scl_r};
        OFF_TRQ_INV:  rdata_nxt = {16'h0000, trq_inv_r};
        OFF_TRQ_SCL:  rdata_nxt = {16'h0000, trq_scl_r};
        OFF_ACC_SCL:  rdata_nxt = {16'h0000, acc_scl_r};
        OFF_ACC_MULT: rdata_nxt = {16'h0000, ACC_MULT_VAL};
        OFF_STATUS:   rdata_nxt = {28'h0000000, link_state_i, 1'b0, rej_r};
        default:      rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_inv_r <= RST_WORD;
      pos_scl_r <= RST_WORD;
      trq_inv_r <= RST_WORD;
      trq_scl_r <= RST_WORD;
      acc_scl_r <= RST_WORD;
      rej_r     <= 1'b0;
      rdata_r   <= 32'h00000000;
    end else begin
      pos_inv_r <= pos_inv_nxt;
      pos_scl_r <= pos_scl_nxt;
      trq_inv_r <= trq_inv_nxt;
      trq_scl_r <= trq_scl_nxt;
      acc_scl_r <= acc_scl_nxt;
      rej_r     <= rej_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign prdata_o = rdata_r;

  // ------------------------------------------------------------
  // scaling decode
  // ------------------------------------------------------------
  function automatic dps_scale_t decode(input logic [15:0] w);
    dps_scale_t s;
    s.method   = w[2:0];
    s.param    = w[BIT_PARAM];
    s.unit_alt = w[BIT_UNIT];
    s.time_alt = w[BIT_TIME];
    s.load_ref = w[BIT_LOAD];
    s.modulo   = w[BIT_MODULO];
    return s;
  endfunction

  // masks already cleared reserved bits, so decode sees zeros there
  assign pos_cfg_o = decode(pos_scl_r);
  assign trq_cfg_o = decode(trq_scl_r);
  assign acc_cfg_o = decode(acc_scl_r);

  // ------------------------------------------------------------
  // polarity path
  // ------------------------------------------------------------
  // two's complement negation; the most negative value maps to itself
  dps_pos_vals_t pos_out_r, pos_out_nxt;
  dps_trq_vals_t trq_out_r, trq_out_nxt;

  always_comb begin
    pos_out_nxt.cmd = pos_inv_r[BIT_CMD] ? -pos_in_i.cmd : pos_in_i.cmd;
    pos_out_nxt.add = pos_inv_r[BIT_ADD] ? -pos_in_i.add : pos_in_i.add;
    pos_out_nxt.fb1 = pos_inv_r[BIT_FB1] ? -pos_in_i.fb1 : pos_in_i.fb1;
    pos_out_nxt.fb2 = pos_inv_r[BIT_FB2] ? -pos_in_i.fb2 : pos_in_i.fb2;
    trq_out_nxt.cmd = trq_inv_r[BIT_CMD] ? -trq_in_i.cmd : trq_in_i.cmd;
    trq_out_nxt.add = trq_inv_r[BIT_ADD] ? -trq_in_i.add : trq_in_i.add;
    trq_out_nxt.fb  = trq_inv_r[BIT_FB1] ? -trq_in_i.fb  : trq_in_i.fb;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_out_r <= '0;
      trq_out_r <= '0;
    end else begin
      pos_out_r <= pos_out_nxt;
      trq_out_r <= trq_out_nxt;
    end
  end

  assign pos_out_o = pos_out_r;
  assign trq_out_o = trq_out_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  chk_pos_cmd_inv: assert property (
    ##1 pos_out_o.cmd == ($past(pos_inv_r[BIT_CMD]) ? -$past(pos_in_i.cmd) : $past(pos_in_i.cmd)))
    else $error("position command polarity wrong");
  chk_pos_fb2_pass: assert property (
    !pos_inv_r[BIT_FB2] |=> pos_out_o.fb2 == $past(pos_in_i.fb2))
    else $error("position feedback 2 altered without inversion");
  chk_trq_fb_inv: assert property (
    trq_inv_r[BIT_FB1] |=> trq_out_o.fb == -$past(trq_in_i.fb))
    else $error("torque feedback not inverted");
  chk_pos_modulo_wr: assert property (
    wr_ok && paddr_i == OFF_POS_SCL |=> pos_cfg_o.modulo == $past(pwdata_i[BIT_MODULO]))
    else $error("modulo bit not taken");
  chk_trq_param_wr: assert property (
    wr_ok && paddr_i == OFF_TRQ_SCL |=> trq_cfg_o.param == $past(pwdata_i[BIT_PARAM]))
    else $error("parameter scaling bit not taken");
  chk_acc_load_time: assert property (
    wr_ok && paddr_i == OFF_ACC_SCL |=> acc_cfg_o.time_alt == $past(pwdata_i[BIT_TIME]) &&
      acc_cfg_o.load_ref == $past(pwdata_i[BIT_LOAD]) && acc_cfg_o.method == $past(pwdata_i[2:0]))
    else $error("acceleration scaling word not taken");
  chk_pos_reserved: assert property (
    pos_scl_r[15:8] == 8'h00 && !pos_scl_r[BIT_UNIT] && !pos_scl_r[BIT_TIME])
    else $error("position scaling reserved bit set");
  chk_trq_reserved: assert property (
    trq_scl_r[15:7] == 9'h000 && !trq_scl_r[BIT_UNIT] && !trq_scl_r[BIT_TIME] && trq_inv_r[15:3] == 13'h0000)
    else $error("torque reserved bit set");
  chk_gate_write: assert property (
    access && pwrite_i && link_state_i != DPS_LINK_PREOP |=> $stable(pos_inv_r) && $stable(pos_scl_r) &&
      $stable(trq_inv_r) && $stable(trq_scl_r) && $stable(acc_scl_r))
    else $error("write accepted outside pre-operational state");
  chk_reject_flag: assert property (
    wr_rej |=> rej_r)
    else $error("rejected write not flagged");
  chk_mult_read: assert property (
    setup && !pwrite_i && paddr_i == OFF_ACC_MULT |=> prdata_o == 32'h00000001)
    else $error("multiplier reads wrong");
  chk_read_upper: assert property (
    pready_o |-> prdata_o[31:16] == 16'h0000 && pos_inv_r[15:4] == 12'h000)
    else $error("reserved bits read nonzero");

  // ------------------------------------------------------------
  // checks: the remaining polarity bit cases, inverted and passed
  // ------------------------------------------------------------
  chk_pos_add_inv: assert property (
    pos_inv_r[BIT_ADD] |=> pos_out_o.add == -$past(pos_in_i.add))
    else $error("additive position command not inverted");
  chk_pos_fb1_inv: assert property (
    pos_inv_r[BIT_FB1] |=> pos_out_o.fb1 == -$past(pos_in_i.fb1))
    else $error("position feedback 1 not inverted");
  chk_pos_fb2_inv: assert property (
    pos_inv_r[BIT_FB2] |=> pos_out_o.fb2 == -$past(pos_in_i.fb2))
    else $error("position feedback 2 not inverted");
  chk_pos_add_pass: assert property (
    !pos_inv_r[BIT_ADD] |=> pos_out_o.add == $past(pos_in_i.add))
    else $error("additive position command altered without inversion");
  chk_pos_fb1_pass: assert property (
    !pos_inv_r[BIT_FB1] |=> pos_out_o.fb1 == $past(pos_in_i.fb1))
    else $error("position feedback 1 altered without inversion");
  chk_trq_cmd_inv: assert property (
    trq_inv_r[BIT_CMD] |=> trq_out_o.cmd == -$past(trq_in_i.cmd))
    else $error("torque command not inverted");
  chk_trq_add_inv: assert property (
    trq_inv_r[BIT_ADD] |=> trq_out_o.add == -$past(trq_in_i.add))
    else $error("additive torque command not inverted");
  chk_trq_cmd_pass: assert property (
    !trq_inv_r[BIT_CMD] |=> trq_out_o.cmd == $past(trq_in_i.cmd))
    else $error("torque command altered without inversion");
  chk_trq_add_pass: assert property (
    !trq_inv_r[BIT_ADD] |=> trq_out_o.add == $past(trq_in_i.add))
    else $error("additive torque command altered without inversion");
  chk_trq_fb_pass: assert property (
    !trq_inv_r[BIT_FB1] |=> trq_out_o.fb == $past(trq_in_i.fb))
    else $error("torque feedback altered without inversion");

  // ------------------------------------------------------------
  // checks: scaling fields, write gating and unmapped reads
  // ------------------------------------------------------------
  // fields are checked one by one so a swapped bit shows which field it hit
  chk_pos_method_wr: assert property (
    wr_ok && paddr_i == OFF_POS_SCL |=> pos_cfg_o.method == $past(pwdata_i[2:0]))
    else $error("position scaling method not taken");
  chk_pos_param_wr: assert property (
    wr_ok && paddr_i == OFF_POS_SCL |=> pos_cfg_o.param == $past(pwdata_i[BIT_PARAM]))
    else $error("position parameter scaling bit not taken");
  chk_pos_load_wr: assert property (
    wr_ok && paddr_i == OFF_POS_SCL |=> pos_cfg_o.load_ref == $past(pwdata_i[BIT_LOAD]))
    else $error("position data reference bit not taken");
  chk_trq_method_wr: assert property (
    wr_ok && paddr_i == OFF_TRQ_SCL |=> trq_cfg_o.method == $past(pwdata_i[2:0]))
    else $error("torque scaling method not taken");
  chk_acc_unit_wr: assert property (
    wr_ok && paddr_i == OFF_ACC_SCL |=> acc_cfg_o.unit_alt == $past(pwdata_i[BIT_UNIT]))
    else $error("acceleration unit bit not taken");
  chk_acc_param_wr: assert property (
    wr_ok && paddr_i == OFF_ACC_SCL |=> acc_cfg_o.param == $past(pwdata_i[BIT_PARAM]))
    else $error("acceleration parameter scaling bit not taken");
  chk_preop_write: assert property (
    wr_ok && paddr_i == OFF_POS_INV |=> pos_inv_r == ($past(pwdata_i[15:0]) & MASK_POS_INV))
    else $error("pre-operational write not taken");
  chk_reject_clear: assert property (
    access && pwrite_i && paddr_i == OFF_STATUS && pwdata_i[BIT_REJECTED] |=> !rej_r)
    else $error("rejected-write flag not cleared");
  chk_acc_reserved: assert property (
    acc_scl_r[15:7] == 9'h000 && pos_inv_r[15:4] == 12'h000)
    else $error("acceleration or position polarity reserved bit set");
  chk_unmapped_read: assert property (
    setup && !mapped |=> prdata_o == 32'h00000000)
    else $error("unmapped address reads nonzero");

  cov_pos_write: cover property (wr_ok && paddr_i == OFF_POS_INV && pwdata_i[BIT_CMD]);
  cov_rejected:  cover property (wr_rej);
  cov_ramp_time: cover property (acc_cfg_o.method == 3'h3);
  cov_unmapped:  cover property (pslverr_o);
  cov_clear:     cover property (access && pwrite_i && paddr_i == OFF_STATUS && pwdata_i[BIT_REJECTED] && rej_r);

endmodule

// *** rtl/dps_pkg.sv ***
package dps_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_POS_INV  = 8'h00;
  localparam logic [7:0] OFF_POS_SCL  = 8'h04;
  localparam logic [7:0] OFF_TRQ_INV  = 8'h08;
  localparam logic [7:0] OFF_TRQ_SCL  = 8'h0c;
  localparam logic [7:0] OFF_ACC_SCL  = 8'h10;
  localparam logic [7:0] OFF_ACC_MULT = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;

  // ------------------------------------------------------------
  // writable bit masks and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] MASK_POS_INV = 16'h000f;
  localparam logic [15:0] MASK_TRQ_INV = 16'h0007;
  localparam logic [15:0] MASK_POS_SCL = 16'h00cf;
  localparam logic [15:0] MASK_TRQ_SCL = 16'h004f;
  localparam logic [15:0] MASK_ACC_SCL = 16'h007f;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [15:0] ACC_MULT_VAL = 16'h0001;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_CMD      = 0;
  localparam int BIT_ADD      = 1;
  localparam int BIT_FB1      = 2;
  localparam int BIT_FB2      = 3;
  localparam int BIT_PARAM    = 3;
  localparam int BIT_UNIT     = 4;
  localparam int BIT_TIME     = 5;
  localparam int BIT_LOAD     = 6;
  localparam int BIT_MODULO   = 7;
  localparam int BIT_REJECTED = 0;

  typedef enum logic [1:0] {
    DPS_LINK_INIT,
    DPS_LINK_PREOP,
    DPS_LINK_SAFEOP,
    DPS_LINK_OP
  } dps_link_t;

  typedef struct packed {
    logic signed [31:0] cmd;
    logic signed [31:0] add;
    logic signed [31:0] fb1;
    logic signed [31:0] fb2;
  } dps_pos_vals_t;

  typedef struct packed {
    logic signed [15:0] cmd;
    logic signed [15:0] add;
    logic signed [15:0] fb;
  } dps_trq_vals_t;

  typedef struct packed {
    logic [2:0] method;
    logic       param;
    logic       unit_alt;
    logic       time_alt;
    logic       load_ref;
    logic       modulo;
  } dps_scale_t;

endpackage

// *** verif/dps_fbm_model.sv ***
`timescale 1ns/1ns
// fieldbus master: apb cycles and link state
module dps_fbm_model (
  input  wire logic        clk_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output dps_pkg::dps_link_t link_o
);
  import dps_pkg::*;
  initial begin
    {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
    link_o = DPS_LINK_PREOP;
  end
  // writes outside preop happen only in the bench's locked-word loop and its status clear
  task automatic set_link(input dps_link_t s);
    @(posedge clk_i);
    link_o <= s;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output bit ok);
    ok = 0;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk_i);
      if (pready_i === 1'b1) begin
        ok = 1;
        r = prdata_i;
        e = pslverr_i;
      end
    end
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released bus shows no stale value
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule

// *** verif/dps_param_bank_test.sv ***
`timescale 1ns/1ns
module dps_param_bank_test;
  import dps_pkg::*;
  logic sys_clk_i = 0, rstn_i = 0, psel, pen, pwr, prdy, perr, e;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, r;
  dps_link_t     link;
  dps_pos_vals_t pos_in = '0, pos_out, pv = '0;
  dps_trq_vals_t trq_in = '0, trq_out, tv = '0;
  dps_scale_t    pcfg, tcfg, acfg;
  logic [15:0]   lfsr_s = 16'h0060, v, shadow [5];
  logic [7:0]    offs [5] = '{OFF_POS_INV, OFF_POS_SCL, OFF_TRQ_INV, OFF_TRQ_SCL, OFF_ACC_SCL};
  logic [15:0]   msk [5] = '{MASK_POS_INV, MASK_POS_SCL, MASK_TRQ_INV, MASK_TRQ_SCL, MASK_ACC_SCL};
  int            n_mismatch = 0, total_checks = 0;
  initial forever #2 sys_clk_i = ~sys_clk_i;
  dps_fbm_model u_m (.clk_i(sys_clk_i), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr),
    .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(prdy), .pslverr_i(perr), .link_o(link));
  dps_param_bank dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(prdy),
    .pslverr_o(perr), .link_state_i(link), .pos_in_i(pos_in), .trq_in_i(trq_in), .pos_out_o(pos_out),
    .trq_out_o(trq_out), .pos_cfg_o(pcfg), .trq_cfg_o(tcfg), .acc_cfg_o(acfg));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic dps_scale_t exp_cfg(input logic [15:0] w);
    return {w[2:0], w[3], w[4], w[5], w[6], w[7]};
  endfunction
  function automatic dps_pos_vals_t exp_pos(input dps_pos_vals_t p, input logic [15:0] w);
    exp_pos = p;
    if (w[0]) exp_pos.cmd = -p.cmd;
    if (w[1]) exp_pos.add = -p.add;
    if (w[2]) exp_pos.fb1 = -p.fb1;
    if (w[3]) exp_pos.fb2 = -p.fb2;
  endfunction
  function automatic dps_trq_vals_t exp_trq(input dps_trq_vals_t t, input logic [15:0] w);
    exp_trq = t;
    if (w[0]) exp_trq.cmd = -t.cmd;
    if (w[1]) exp_trq.add = -t.add;
    if (w[2]) exp_trq.fb = -t.fb;
  endfunction
  task automatic chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (x !== g) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_flag(input string n, input logic x, input logic g);
    total_checks++;
    if (x !== g) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", n, x, g);
    end
  endtask
  task automatic chk_cfg(input string n, input dps_scale_t x, input dps_scale_t g);
    total_checks++;
    if (x !== g) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_pos(input string n, input dps_pos_vals_t x, input dps_pos_vals_t g);
    total_checks++;
    if (x !== g) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_trq(input string n, input dps_trq_vals_t x, input dps_trq_vals_t g);
    total_checks++;
    if (x !== g) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d of %0d checks", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    bit ok;
    u_m.xfer(w, a, d, r, e, ok);
    if (!ok) begin
      n_mismatch++;
      summarize();
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rw(0, offs[i], 0);
      chk_word("reset word", 32'h00000000, r);
    end
    rw(1, OFF_ACC_MULT, 32'h0000_0010);
    rw(0, OFF_ACC_MULT, 0);
    chk_word("accel multiplier", {16'h0000, ACC_MULT_VAL}, r);
    rw(0, 8'h1c, 0);
    chk_flag("unmapped error", 1'b1, e);
    chk_word("unmapped read", 32'h00000000, r);
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 5; i++) begin
        lfsr_s = lfsr(lfsr_s);
        v = (k == 0) ? 16'hffff : (k == 1) ? 16'h0003 : lfsr_s;
        rw(1, offs[i], {~lfsr_s, v});
        shadow[i] = v & msk[i];
        rw(0, offs[i], 0);
        chk_word("readback", {16'h0000, shadow[i]}, r);
        chk_flag("mapped error", 1'b0, e);
      end
      chk_cfg("pos cfg", exp_cfg(shadow[1]), pcfg);
      chk_cfg("trq cfg", exp_cfg(shadow[3]), tcfg);
      chk_cfg("acc cfg", exp_cfg(shadow[4]), acfg);
      @(posedge sys_clk_i);
      for (int j = 0; j < 11; j++) begin
        lfsr_s = lfsr(lfsr_s);
        pv = {pv[111:0], lfsr_s};
        tv = {tv[31:0], ~lfsr_s};
      end
      // most negative values first, with every polarity bit set
      if (k == 0) begin
        pv.cmd = 32'h80000000;
        tv.fb = 16'h8000;
      end
      pos_in <= pv;
      trq_in <= tv;
      @(posedge sys_clk_i);
      #1;
      chk_pos("pos out", exp_pos(pv, shadow[0]), pos_out);
      chk_trq("trq out", exp_trq(tv, shadow[2]), trq_out);
    end
    // writes while not preop leave every word alone
    for (int s = 0; s < 4; s++) begin
      if (s == 1) continue;
      u_m.set_link(dps_link_t'(s));
      for (int i = 0; i < 5; i++) begin
        rw(1, offs[i], {16'h0000, ~shadow[i]});
        rw(0, offs[i], 0);
        chk_word("locked word", {16'h0000, shadow[i]}, r);
      end
    end
    rw(0, OFF_STATUS, 0);
    chk_word("status flag", {28'h0000000, DPS_LINK_OP, 1'b0, 1'b1}, r);
    rw(1, OFF_STATUS, 32'h00000001);
    rw(0, OFF_STATUS, 0);
    chk_word("status clear", {28'h0000000, DPS_LINK_OP, 1'b0, 1'b0}, r);
    u_m.set_link(DPS_LINK_PREOP);
    rw(1, OFF_POS_INV, 32'h00000005);
    rw(0, OFF_POS_INV, 0);
    chk_word("preop write", 32'h00000005, r);
    summarize();
  end
endmodule
